// File: inc/strap_reset_defs.svh
`ifndef STRAP_RESET_DEFS_SVH
`define STRAP_RESET_DEFS_SVH
`define SW_MODE_NORMAL      4'h0
`define SW_MODE_EEPROM      4'h1
`define SW_MODE_RESV_FIRST  4'h2
`define MGMT_FAST_KHZ       400
`define MGMT_SLOW_KHZ       100
`define CLK_SYS_KHZ         50000
`define MGMT_FAST_DIV       ((`CLK_SYS_KHZ / `MGMT_FAST_KHZ) / 2)
`define MGMT_SLOW_DIV       ((`CLK_SYS_KHZ / `MGMT_SLOW_KHZ) / 2)
`define RESET_PROC_NS       200
`define RESET_PROC_CYC      ((`RESET_PROC_NS + 19) / 20)
`define GPIO_WIDTH          11
`define GPIO_EVENT          7
`define GPIO_P2RST          0
`define GPIO_P4RST          1
`define GPIO_P3RST          9
`define GPIO_P5RST          10
`define NUM_DS_PORTS        4
`define SYNC_RST_VAL        10'h001
`endif

// File: inc/strap_reset_pkg.sv
package strap_reset_pkg;
  typedef enum logic [1:0] {
    SEQ_IN_RESET,
    SEQ_PROC,
    SEQ_HELD,
    SEQ_RUN
  } seq_state_t;
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_EEPROM,
    MODE_RESERVED
  } op_mode_t;
endpackage : strap_reset_pkg

// File: core/switch_strap_reset_control.sv
`timescale 1ns/1ps
`include "strap_reset_defs.svh"
module switch_strap_reset_control (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  input  wire logic                     fundamental_reset_n,
  input  wire logic                     aux_power_disable,
  input  wire logic                     downstream_common_clock_strap,
  input  wire logic                     upstream_common_clock_strap,
  input  wire logic                     mgmt_slow_mode,
  input  wire logic                     reset_hold,
  input  wire logic [2:0]               switch_mode,
  input  wire logic                     hold_clear,
  input  wire logic                     ds_sclk_wr,
  input  wire logic [3:0]               ds_sclk_wdata,
  input  wire logic                     us_sclk_wr,
  input  wire logic                     us_sclk_wdata,
  input  wire logic                     wake_dir_a,
  input  wire logic                     wake_req,
  input  wire logic                     wake_pin_in,
  input  wire logic [`GPIO_WIDTH-1:0]   gpio_alt_sel,
  input  wire logic [`GPIO_WIDTH-1:0]   gpio_out_val,
  input  wire logic [`GPIO_WIDTH-1:0]   gpio_dir_out,
  input  wire logic                     event_req,
  input  wire logic [3:0]               port_reset_req,
  output logic [`GPIO_WIDTH-1:0]        gpio_out,
  output logic [`GPIO_WIDTH-1:0]        gpio_oe_n,
  output logic                          wake_pin_out,
  output logic                          wake_pin_oe_n,
  output logic                          wake_seen,
  output logic                          aux_power_en,
  output logic [3:0]                    ds_link_status_sclk,
  output logic                          upstream_link_status_sclk,
  output logic [8:0]                    mgmt_clk_div,
  output logic                          mgmt_slow,
  output logic                          pcie_fund_reset,
  output logic                          core_reset_n,
  output logic                          mgmt_bus_en,
  output logic                          reset_hold_bit,
  output logic                          eeprom_load,
  output logic                          mode_reserved
);

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for pins
  localparam int unsigned SYNC_W = 10;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  wire  [SYNC_W-1:0] raw_pins = {fundamental_reset_n, aux_power_disable,
                                 downstream_common_clock_strap,
                                 upstream_common_clock_strap, mgmt_slow_mode,
                                 reset_hold, switch_mode, wake_pin_in};

  // wake pin idles released high, so its stages reset high: no false wake
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= `SYNC_RST_VAL;
      sync2 <= `SYNC_RST_VAL;
    end else if (clk_en) begin
      sync1 <= raw_pins;
      sync2 <= sync1;
    end
  end

  wire       fund_n_s  = sync2[9];
  wire       aux_dis_s = sync2[8];
  wire       ds_cc_s   = sync2[7];
  wire       us_cc_s   = sync2[6];
  wire       slow_s    = sync2[5];
  wire       hold_s    = sync2[4];
  wire [2:0] mode_s    = sync2[3:1];
  wire       wake_s    = sync2[0];

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  strap_reset_pkg::seq_state_t state;
  strap_reset_pkg::seq_state_t next_state;
  logic [7:0] proc_cnt;
  logic       latched;
  logic       s_slow;
  logic       s_aux_dis;
  logic [2:0] s_mode;
  strap_reset_pkg::op_mode_t mode_dec;

  function automatic strap_reset_pkg::op_mode_t decode_mode(input logic [2:0] code);
    if (code >= 3'(`SW_MODE_RESV_FIRST)) begin
      decode_mode = strap_reset_pkg::MODE_RESERVED;
    end else if (code == 3'(`SW_MODE_EEPROM)) begin
      decode_mode = strap_reset_pkg::MODE_EEPROM;
    end else begin
      decode_mode = strap_reset_pkg::MODE_NORMAL;
    end
  endfunction : decode_mode

  assign mode_dec = decode_mode(s_mode);

  always_comb begin
    next_state = state;
    case (state)
      strap_reset_pkg::SEQ_IN_RESET:
        if (fund_n_s) next_state = strap_reset_pkg::SEQ_PROC;
      strap_reset_pkg::SEQ_PROC:
        if (proc_cnt == 8'(`RESET_PROC_CYC - 1))
          next_state = reset_hold_bit ? strap_reset_pkg::SEQ_HELD
                                      : strap_reset_pkg::SEQ_RUN;
      strap_reset_pkg::SEQ_HELD:
        if (!reset_hold_bit) next_state = strap_reset_pkg::SEQ_RUN;
      strap_reset_pkg::SEQ_RUN:
        next_state = strap_reset_pkg::SEQ_RUN;
      default:
        next_state = strap_reset_pkg::SEQ_IN_RESET;
    endcase
    if (!fund_n_s) next_state = strap_reset_pkg::SEQ_IN_RESET;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state    <= strap_reset_pkg::SEQ_IN_RESET;
      proc_cnt <= 8'h00;
    end else if (clk_en) begin
      state    <= next_state;
      proc_cnt <= (state == strap_reset_pkg::SEQ_PROC) ? proc_cnt + 8'h01 : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strap latch and software copies
  wire release_edge = !latched && fund_n_s;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      latched                   <= 1'b0;
      s_slow                    <= 1'b0;
      s_aux_dis                 <= 1'b0;
      s_mode                    <= 3'h0;
      reset_hold_bit            <= 1'b0;
      ds_link_status_sclk       <= 4'h0;
      upstream_link_status_sclk <= 1'b0;
    end else if (clk_en) begin
      if (!fund_n_s) begin
        latched        <= 1'b0;
        reset_hold_bit <= hold_s;
      end else if (release_edge) begin
        latched                   <= 1'b1;
        s_slow                    <= slow_s;
        s_aux_dis                 <= aux_dis_s;
        s_mode                    <= mode_s;
        ds_link_status_sclk       <= {`NUM_DS_PORTS{ds_cc_s}};
        upstream_link_status_sclk <= us_cc_s;
        reset_hold_bit            <= hold_s;
      end else begin
        if (hold_clear) reset_hold_bit <= 1'b0;
        if (ds_sclk_wr) ds_link_status_sclk <= ds_sclk_wdata;
        if (us_sclk_wr) upstream_link_status_sclk <= us_sclk_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  wire running = (state == strap_reset_pkg::SEQ_RUN);
  wire [3:0] port_rst_n = running ? ~port_reset_req : 4'h0;
  logic [`GPIO_WIDTH-1:0] alt_val;

  always_comb begin
    alt_val                = gpio_out_val;
    alt_val[`GPIO_EVENT]   = ~(event_req & running);
    alt_val[`GPIO_P3RST]   = port_rst_n[1];
    alt_val[`GPIO_P5RST]   = port_rst_n[3];
    alt_val[`GPIO_P2RST]   = port_rst_n[0];
    alt_val[`GPIO_P4RST]   = port_rst_n[2];
  end

  wire [`GPIO_WIDTH-1:0] alt_mask = (`GPIO_WIDTH'(1) << `GPIO_EVENT)
                                  | (`GPIO_WIDTH'(1) << `GPIO_P3RST)
                                  | (`GPIO_WIDTH'(1) << `GPIO_P5RST)
                                  | (`GPIO_WIDTH'(1) << `GPIO_P2RST)
                                  | (`GPIO_WIDTH'(1) << `GPIO_P4RST);
  wire [`GPIO_WIDTH-1:0] alt_on   = gpio_alt_sel & alt_mask;
  wire [`GPIO_WIDTH-1:0] next_gpio_out = (alt_on & alt_val) | (~alt_on & gpio_out_val);
  wire [`GPIO_WIDTH-1:0] next_gpio_oe_n = ~(alt_on | gpio_dir_out);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gpio_out        <= '0;
      gpio_oe_n       <= '1;
      wake_pin_out    <= 1'b0;
      wake_pin_oe_n   <= 1'b1;
      wake_seen       <= 1'b0;
      aux_power_en    <= 1'b0;
      mgmt_slow       <= 1'b0;
      mgmt_clk_div    <= 9'h000;
      pcie_fund_reset <= 1'b1;
      core_reset_n    <= 1'b0;
      mgmt_bus_en     <= 1'b0;
      eeprom_load     <= 1'b0;
      mode_reserved   <= 1'b0;
    end else if (clk_en) begin
      gpio_out        <= next_gpio_out;
      gpio_oe_n       <= next_gpio_oe_n;
      wake_pin_out    <= 1'b0;
      wake_pin_oe_n   <= ~(wake_dir_a & wake_req);
      wake_seen       <= ~wake_dir_a & ~wake_s;
      aux_power_en    <= latched & ~s_aux_dis;
      mgmt_slow       <= s_slow;
      mgmt_clk_div    <= s_slow ? 9'(`MGMT_SLOW_DIV) : 9'(`MGMT_FAST_DIV);
      pcie_fund_reset <= !fund_n_s;
      core_reset_n    <= running;
      mgmt_bus_en     <= latched;
      eeprom_load     <= running && (mode_dec == strap_reset_pkg::MODE_EEPROM);
      mode_reserved   <= latched && (mode_dec == strap_reset_pkg::MODE_RESERVED);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_proc_done;
    clk_en && fund_n_s && state == strap_reset_pkg::SEQ_PROC
      && proc_cnt == 8'(`RESET_PROC_CYC - 1);
  endsequence

  sequence s_proc_free;
    s_proc_done ##0 !reset_hold_bit;
  endsequence

  sequence s_run_then_core;
    running ##1 core_reset_n;
  endsequence

  a_hold_keeps_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && state == strap_reset_pkg::SEQ_HELD && reset_hold_bit |=> !running)
    else $error("held device left reset");
  a_clear_releases: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && state == strap_reset_pkg::SEQ_HELD && !reset_hold_bit && fund_n_s
    |=> running)
    else $error("hold clear did not release");
  a_fund_resets: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && !fund_n_s |=> !running && !latched && pcie_fund_reset)
    else $error("fundamental reset ignored");
  a_proc_stays: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && fund_n_s && state == strap_reset_pkg::SEQ_PROC
    && proc_cnt < 8'(`RESET_PROC_CYC - 1) |=> state == strap_reset_pkg::SEQ_PROC)
    else $error("reset procedure cut short");
  a_proc_to_run: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_proc_free ##1 clk_en |-> s_run_then_core)
    else $error("free device not released");
  a_proc_to_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_proc_done ##0 reset_hold_bit |=> state == strap_reset_pkg::SEQ_HELD && !core_reset_n)
    else $error("held device not parked");
  a_bus_in_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && state == strap_reset_pkg::SEQ_HELD |=> mgmt_bus_en)
    else $error("management bus off while held");
  a_slow_div: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && s_slow |=> !clk_en || mgmt_clk_div == 9'(`MGMT_SLOW_DIV))
    else $error("slow mode divider wrong");
  a_straps_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    latched && $past(latched) |-> $stable(s_mode) && $stable(s_slow))
    else $error("latched straps changed");
  a_wake_dir: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && !wake_dir_a |=> !clk_en || wake_pin_oe_n)
    else $error("wake pin driven while input");
  a_wake_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && wake_dir_a && wake_req |=> !wake_pin_oe_n && !wake_pin_out)
    else $error("wake pin not driven low");
  a_aux_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && s_aux_dis |=> !clk_en || !aux_power_en)
    else $error("aux power used while disabled");
  a_event_pin: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && gpio_alt_sel[`GPIO_EVENT] |=> !clk_en || !gpio_oe_n[`GPIO_EVENT])
    else $error("event pin not driven");
  a_port_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && !running && gpio_alt_sel[`GPIO_P3RST]
    |=> !clk_en || !gpio_out[`GPIO_P3RST])
    else $error("port 3 reset not asserted");
  a_port5_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && !running && gpio_alt_sel[`GPIO_P5RST]
    |=> !gpio_out[`GPIO_P5RST])
    else $error("port 5 reset not asserted");
  a_port24_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && !running && gpio_alt_sel[`GPIO_P2RST] && gpio_alt_sel[`GPIO_P4RST]
    |=> !gpio_out[`GPIO_P2RST] && !gpio_out[`GPIO_P4RST])
    else $error("port 2 or 4 reset not asserted");
  a_ds_sclk_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && latched && fund_n_s && ds_sclk_wr
    |=> ds_link_status_sclk == $past(ds_sclk_wdata))
    else $error("downstream slot clock write lost");
  a_us_sclk_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && latched && fund_n_s && us_sclk_wr
    |=> upstream_link_status_sclk == $past(us_sclk_wdata))
    else $error("upstream slot clock write lost");
  a_sclk_seed: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && release_edge
    |=> ds_link_status_sclk == {`NUM_DS_PORTS{$past(ds_cc_s)}}
        && upstream_link_status_sclk == $past(us_cc_s))
    else $error("slot clock bits not seeded");
  a_mode_normal: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && latched && s_mode == 3'(`SW_MODE_NORMAL) |=> !eeprom_load && !mode_reserved)
    else $error("normal mode flags wrong");
  a_mode_eeprom: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && running && s_mode == 3'(`SW_MODE_EEPROM) |=> eeprom_load && !mode_reserved)
    else $error("eeprom mode flags wrong");
  a_mode_resv: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && latched && s_mode >= 3'(`SW_MODE_RESV_FIRST) |=> mode_reserved && !eeprom_load)
    else $error("reserved mode flags wrong");

endmodule : switch_strap_reset_control

// File: verification/strap_board_model.sv
`timescale 1ns/1ps
module strap_board_model (
  input  wire logic       clk_sys,
  input  wire logic       fundamental_reset_n,
  input  wire logic [7:0] strap_cfg,
  input  wire logic       clear_cmd,
  output logic      [7:0] strap_pins,
  output logic            hold_clear
);
  logic clear_q;
  initial begin
    strap_pins = 8'h00;
    hold_clear = 1'b0;
    clear_q    = 1'b0;
  end
  // straps only move outside fundamental reset
  always @(posedge clk_sys) begin
    if (fundamental_reset_n) strap_pins <= strap_cfg;
    clear_q    <= clear_cmd;
    hold_clear <= clear_cmd & ~clear_q;
  end
endmodule : strap_board_model

// File: verification/switch_strap_reset_control_tb.sv
`timescale 1ns/1ps
module switch_strap_reset_control_tb;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        fund_n = 1'b1;
  logic        ena = 1'b1;
  logic [7:0]  cfg = 8'h00;
  logic        clr = 1'b0;
  logic [7:0]  pins;
  logic        hclr;
  logic        ds_wr = 1'b0, us_wr = 1'b0, us_wd = 1'b0;
  logic [3:0]  ds_wd = 4'h0;
  logic        wdir = 1'b0, wreq = 1'b0, wext = 1'b0, ev = 1'b0;
  logic [10:0] alt = 11'h000, oval = 11'h000, odir = 11'h000;
  logic [3:0]  prq = 4'h0;
  logic [10:0] g_out, g_oe_n;
  logic [3:0]  ds_sclk;
  logic [8:0]  div;
  logic        w_out, w_oe_n, w_seen, aux_en, us_sclk, slow, f_rst, core_n, bus_en, hold_b;
  logic        ee, resv;
  wire         w_in = (w_oe_n | w_out) & ~wext;
  int          mismatches = 0;
  int          n_tests = 0;
  always #10 clk_sys = ~clk_sys;
  strap_board_model strap_board_model_inst (.clk_sys(clk_sys), .fundamental_reset_n(fund_n),
    .strap_cfg(cfg), .clear_cmd(clr), .strap_pins(pins), .hold_clear(hclr));
  switch_strap_reset_control switch_strap_reset_control_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .clk_en(ena), .fundamental_reset_n(fund_n), .aux_power_disable(pins[0]),
    .downstream_common_clock_strap(pins[1]), .upstream_common_clock_strap(pins[2]),
    .mgmt_slow_mode(pins[3]), .reset_hold(pins[4]), .switch_mode(pins[7:5]),
    .hold_clear(hclr), .ds_sclk_wr(ds_wr), .ds_sclk_wdata(ds_wd), .us_sclk_wr(us_wr),
    .us_sclk_wdata(us_wd), .wake_dir_a(wdir), .wake_req(wreq), .wake_pin_in(w_in),
    .gpio_alt_sel(alt), .gpio_out_val(oval), .gpio_dir_out(odir), .event_req(ev),
    .port_reset_req(prq), .gpio_out(g_out), .gpio_oe_n(g_oe_n), .wake_pin_out(w_out),
    .wake_pin_oe_n(w_oe_n), .wake_seen(w_seen), .aux_power_en(aux_en),
    .ds_link_status_sclk(ds_sclk), .upstream_link_status_sclk(us_sclk), .mgmt_clk_div(div),
    .mgmt_slow(slow), .pcie_fund_reset(f_rst), .core_reset_n(core_n), .mgmt_bus_en(bus_en),
    .reset_hold_bit(hold_b), .eeprom_load(ee), .mode_reserved(resv));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic boot(input logic [7:0] c, output int k);
    cfg <= c;
    cyc(2);
    fund_n <= 1'b0;
    cyc(6);
    check("pcie_fund_reset", f_rst, 1);
    check("core_reset_n", core_n, 0);
    check("mgmt_bus_en", bus_en, 0);
    fund_n <= 1'b1;
    k = 0;
    while (core_n !== 1'b1 && k < 40) begin
      cyc(1);
      k++;
    end
  endtask : boot
  task automatic t_normal;
    int k;
    boot(8'h0b, k);
    check("release time", k >= 12 && k <= 18, 1);
    check("aux_power_en", aux_en, 0);
    check("ds sclk", ds_sclk, 4'hf);
    check("us sclk", us_sclk, 0);
    check("mgmt div", div, 250);
    check("mgmt_slow", slow, 1);
    check("eeprom_load", ee, 0);
    cfg <= 8'hf4;
    cyc(6);
    check("latched", {ds_sclk, div, aux_en, resv}, {4'hf, 9'd250, 2'b00});
    ds_wr <= 1'b1;
    ds_wd <= 4'h5;
    us_wr <= 1'b1;
    us_wd <= 1'b1;
    cyc(1);
    ds_wr <= 1'b0;
    us_wr <= 1'b0;
    cyc(3);
    check("ds sclk write", ds_sclk, 4'h5);
    check("us sclk write", us_sclk, 1);
    $display("test normal boot done");
  endtask : t_normal
  task automatic t_gpio;
    alt <= 11'h683;
    odir <= 11'h010;
    oval <= 11'h010;
    ev <= 1'b1;
    prq <= 4'ha;
    cyc(4);
    check("gpio_out a", g_out, 11'h013);
    check("gpio_oe_n", g_oe_n, 11'h16c);
    ev <= 1'b0;
    prq <= 4'h5;
    cyc(4);
    check("gpio_out b", g_out, 11'h690);
    $display("test gpio done");
  endtask : t_gpio
  task automatic t_freeze;
    ena <= 1'b0;
    ev <= 1'b1;
    cyc(4);
    check("frozen event", g_out, 11'h690);
    ena <= 1'b1;
    cyc(2);
    check("thawed event", g_out, 11'h610);
    ev <= 1'b0;
    $display("test clock enable done");
  endtask : t_freeze
  task automatic t_wake;
    wdir <= 1'b1;
    wreq <= 1'b1;
    cyc(4);
    check("wake drive", {w_oe_n, w_out}, 2'b00);
    wdir <= 1'b0;
    wext <= 1'b1;
    cyc(5);
    check("wake input", {w_oe_n, w_seen}, 2'b11);
    wext <= 1'b0;
    wreq <= 1'b0;
    cyc(5);
    check("wake idle", w_seen, 0);
    $display("test wake done");
  endtask : t_wake
  task automatic t_hold;
    int k;
    boot(8'h34, k);
    check("held core", core_n, 0);
    check("hold bit", hold_b, 1);
    check("mgmt_bus_en", bus_en, 1);
    check("eeprom held", ee, 0);
    check("held resets", g_out & 11'h603, 11'h000);
    check("mgmt div", div, 62);
    check("sclk", {ds_sclk, us_sclk}, 5'h01);
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    cyc(5);
    check("released", {core_n, hold_b}, 2'b10);
    check("aux_power_en", aux_en, 1);
    check("eeprom_load", ee, 1);
    $display("test hold done");
  endtask : t_hold
  task automatic t_resv;
    int k;
    boot(8'h40, k);
    check("mode 2", {resv, ee}, 2'b10);
    boot(8'he0, k);
    check("mode 7", {resv, ee}, 2'b10);
    boot(8'h00, k);
    check("mode 0", {resv, ee}, 2'b00);
    $display("test modes done");
  endtask : t_resv
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
  initial begin
    cyc(12);
    rst_n <= 1'b1;
    cyc(2);
    check("reset oe_n", g_oe_n, 11'h7ff);
    check("reset core", {f_rst, core_n}, 2'b10);
    t_normal();
    t_gpio();
    t_freeze();
    t_wake();
    t_hold();
    t_resv();
    give_verdict();
  end
endmodule : switch_strap_reset_control_tb
